//--- common/rdm_pkg.sv
// constants for the reference divider and upper interrupt mask registers
package rdm_pkg;
    localparam logic [7:0]  RDM_ADDR_IRQ_UPPER = 8'h45;
    localparam logic [7:0]  RDM_ADDR_DIV_LOW   = 8'h46;
    localparam logic [7:0]  RDM_ADDR_DIV_HIGH  = 8'h47;
    localparam logic [7:0]  RDM_RST_IRQ_UPPER  = 8'h00;
    localparam logic [7:0]  RDM_RST_DIV_LOW    = 8'hFF;
    localparam logic [5:0]  RDM_RST_DIV_HIGH   = 6'h3F;
    localparam int          RDM_BIT_SIGNAL_LOSS   = 0;
    localparam int          RDM_BIT_CODE_VIOL     = 1;
    localparam logic [13:0] RDM_DIV_MAX_SAFE   = 14'h30D3;
endpackage

//--- core/rdm_regs.sv
// register bank: upper interrupt enable byte, 14-bit pre-divider factor, divider
// ============================================================
// How it works
// (R1) the upper interrupt enable byte is read/write and clears to zero at reset.
// (R2) bit 1 gates input one code-violation interrupts and bit 0 its signal-loss ones.
// (R3) the low divider byte is read/write and resets to all ones.
// (R4) the high divider byte keeps factor bits 13..8 in bits 5..0, reads 7..6 as zero, resets 0x3F.
// (R5) software keeps the factor at or below 12499, since the divider only copes up to 100 MHz.
// (R6) a selected input is divided by the factor plus one, so zero passes it unchanged.
`timescale 1ns/1ps
module rdm_regs
    import rdm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data,
    input  wire logic        in1_code_violation_event,
    input  wire logic        in1_signal_loss_event,
    output logic             in1_code_violation_irq,
    output logic             in1_signal_loss_irq,
    input  wire logic        ref_in_tick,
    output logic             ref_div_tick,
    output logic      [13:0] div_factor,
    output logic             div_factor_unsafe
);
    // ============================================================
    // storage and decode signals
    logic [7:0]  irq_enable_upper_byte;
    logic [7:0]  input_divider_low;
    logic [5:0]  input_divider_high;
    logic        hit_irq_upper;
    logic        hit_div_low;
    logic        hit_div_high;
    logic        wr_irq_upper;
    logic        wr_div_low;
    logic        wr_div_high;
    logic [13:0] live_factor;
    logic [7:0]  next_rd_data;
    logic [13:0] div_count;
    logic [13:0] next_div_count;
    logic        next_ref_div_tick;

    // ============================================================
    // helper functions
    // one compare serves every register of the decode
    function automatic logic addr_is(
        input logic [7:0] bus_addr,
        input logic [7:0] reg_addr
    );
        return bus_addr == reg_addr;
    endfunction

    // the two bytes form one factor for the copy and the counter
    function automatic logic [13:0] join_factor(
        input logic [5:0] high_bits,
        input logic [7:0] low_bits
    );
        return {high_bits, low_bits};
    endfunction

    // (R5) above this the divider is not trusted
    function automatic logic beyond_safe(
        input logic [13:0] factor
    );
        return factor > RDM_DIV_MAX_SAFE;
    endfunction

    // ============================================================
    // address decode
    always_comb begin
        hit_irq_upper = 1'b0;
        hit_div_low   = 1'b0;
        hit_div_high  = 1'b0;
        if (addr_is(addr, RDM_ADDR_IRQ_UPPER)) begin
            hit_irq_upper = 1'b1;
        end else if (addr_is(addr, RDM_ADDR_DIV_LOW)) begin
            hit_div_low = 1'b1;
        end else if (addr_is(addr, RDM_ADDR_DIV_HIGH)) begin
            hit_div_high = 1'b1;
        end
    end

    // writes to any other address fall through and change nothing
    always_comb begin
        wr_irq_upper = wr_en & hit_irq_upper;
        wr_div_low   = wr_en & hit_div_low;
        wr_div_high  = wr_en & hit_div_high;
    end

    // ============================================================
    // register bytes
    // (R1) mask byte storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_enable_upper_byte <= RDM_RST_IRQ_UPPER;
        end else if (wr_irq_upper) begin
            irq_enable_upper_byte <= wr_data;
        end
    end

    // (R3) low factor byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            input_divider_low <= RDM_RST_DIV_LOW;
        end else if (wr_div_low) begin
            input_divider_low <= wr_data;
        end
    end

    // (R4) high factor bits, top two dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            input_divider_high <= RDM_RST_DIV_HIGH;
        end else if (wr_div_high) begin
            input_divider_high <= wr_data[5:0];
        end
    end

    // the counter uses this live value, not the delayed copy on the port
    assign live_factor = join_factor(input_divider_high, input_divider_low);

    // ============================================================
    // read port, registered; unmapped addresses read zero
    always_comb begin
        next_rd_data = rd_data;
        if (rd_en) begin
            if (hit_irq_upper) begin
                next_rd_data = irq_enable_upper_byte;
            end else if (hit_div_low) begin
                next_rd_data = input_divider_low;
            end else if (hit_div_high) begin
                // (R4) unused bits read zero
                next_rd_data = {2'h0, input_divider_high};
            end else begin
                next_rd_data = 8'h00;
            end
        end
    end

    // data holds between reads so a slow host may pick it up late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // ============================================================
    // interrupt gating
    // (R2) bit 1 gates violations
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in1_code_violation_irq <= 1'b0;
        end else begin
            in1_code_violation_irq <= in1_code_violation_event
                                      & irq_enable_upper_byte[RDM_BIT_CODE_VIOL];
        end
    end

    // (R2) bit 0 gates loss
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in1_signal_loss_irq <= 1'b0;
        end else begin
            in1_signal_loss_irq <= in1_signal_loss_event
                                   & irq_enable_upper_byte[RDM_BIT_SIGNAL_LOSS];
        end
    end

    // ============================================================
    // registered factor copy and safety flag
    // copy lags the registers by one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_factor <= {RDM_RST_DIV_HIGH, RDM_RST_DIV_LOW};
        end else begin
            div_factor <= live_factor;
        end
    end

    // (R5) flag only; a bad factor is not clamped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // the reset factor is itself beyond the limit
            div_factor_unsafe <= 1'b1;
        end else begin
            div_factor_unsafe <= beyond_safe(live_factor);
        end
    end

    // ============================================================
    // pre-divider
    // (R6) divide by factor plus one
    always_comb begin
        next_div_count    = div_count;
        next_ref_div_tick = 1'b0;
        if (ref_in_tick) begin
            // >= rather than ==: a factor lowered mid-period ends it at once
            if (div_count >= live_factor) begin
                next_div_count    = 14'h0000;
                next_ref_div_tick = 1'b1;
            end else begin
                next_div_count = div_count + 14'h0001;
            end
        end
    end

    // position inside the current divide period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_count <= 14'h0000;
        end else begin
            div_count <= next_div_count;
        end
    end

    // one-cycle pulse per finished period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_div_tick <= 1'b0;
        end else begin
            ref_div_tick <= next_ref_div_tick;
        end
    end
endmodule

//--- test/rdm_regs_monitor.sv
// checker for the divider and upper mask register bank
`timescale 1ns/1ps
module rdm_regs_monitor
    import rdm_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wr_data,
    input wire logic [7:0]  rd_data,
    input wire logic        in1_code_violation_event,
    input wire logic        in1_code_violation_irq,
    input wire logic        ref_in_tick,
    input wire logic        ref_div_tick,
    input wire logic [13:0] div_factor
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // =====
    // a write then a read of the same place
    sequence wr_rd(a);
        wr_en && addr == a ##1 rd_en && !wr_en && addr == a;
    endsequence
    mask_store_a: assert property (wr_rd(RDM_ADDR_IRQ_UPPER) |=>
        rd_data == $past(wr_data, 2)) else $error("mask readback wrong");
    low_store_a: assert property (wr_rd(RDM_ADDR_DIV_LOW) |=>
        rd_data == $past(wr_data, 2)) else $error("low factor readback wrong");
    high_store_a: assert property (wr_rd(RDM_ADDR_DIV_HIGH) |=>
        rd_data[5:0] == $past(wr_data[5:0], 2)) else $error("high factor readback wrong");
    high_unused_a: assert property (rd_en && addr == RDM_ADDR_DIV_HIGH |=>
        rd_data[7:6] == 2'b00) else $error("unused high bits read set");
    viol_gate_a: assert property (in1_code_violation_irq |->
        $past(in1_code_violation_event)) else $error("irq without event");
    // a write just before could change the live factor, so it is excluded
    div_zero_a: assert property (div_factor == 14'h0 && ref_in_tick && !$past(wr_en)
        |=> ref_div_tick) else $error("factor zero did not pass tick");
endmodule
bind rdm_regs rdm_regs_monitor mon (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .ref_in_tick(ref_in_tick),
    .in1_code_violation_event(in1_code_violation_event), .div_factor(div_factor),
    .in1_code_violation_irq(in1_code_violation_irq), .ref_div_tick(ref_div_tick));

//--- test/test_rdm_regs.sv
// self-checking bench for the divider and upper mask register bank
`timescale 1ns/1ps
module test_rdm_regs
    import rdm_pkg::*;
;
    logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, cv = 0, sl = 0, tick = 0, ci, si, dt, uns;
    logic [7:0]  addr = 0, wd = 0, rd, d;
    logic [13:0] df;
    int          errors = 0, n_compared = 0, nd = 0, k;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (dt === 1'b1) nd++;
    rdm_regs dut (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wd), .rd_data(rd), .in1_code_violation_event(cv), .in1_signal_loss_event(sl),
        .in1_code_violation_irq(ci), .in1_signal_loss_irq(si), .ref_in_tick(tick),
        .ref_div_tick(dt), .div_factor(df), .div_factor_unsafe(uns));
    // =====
    task chk(string n, logic [13:0] e, logic [13:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task chk_rd(string n, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task chk_bit(string n, logic e, logic g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] v);
        @(negedge clk); wr_en = 1; addr = a; wd = v;
        @(negedge clk); wr_en = 0;
    endtask
    task rdr(logic [7:0] a);
        @(negedge clk); rd_en = 1; addr = a;
        @(negedge clk); rd_en = 0;
    endtask
    // read on the edge right after the write, the tightest legal spacing
    task wr_then_rd(logic [7:0] a, logic [7:0] v);
        @(negedge clk); wr_en = 1; addr = a; wd = v;
        @(negedge clk); wr_en = 0; rd_en = 1;
        @(negedge clk); rd_en = 0;
    endtask
    function logic exp_unsafe(logic [13:0] f);
        return f > RDM_DIV_MAX_SAFE;
    endfunction
    task check_reset;
        chk("factor reset", {RDM_RST_DIV_HIGH, RDM_RST_DIV_LOW}, df);
        chk_bit("unsafe reset", exp_unsafe({RDM_RST_DIV_HIGH, RDM_RST_DIV_LOW}), uns);
        rdr(RDM_ADDR_IRQ_UPPER); chk_rd("mask reset", 8'h00, rd);
        rdr(RDM_ADDR_DIV_LOW); chk_rd("low reset", 8'hFF, rd);
        rdr(RDM_ADDR_DIV_HIGH); chk_rd("high reset", 8'h3F, rd);
        chk_bit("viol irq reset", 1'b0, ci);
        chk_bit("loss irq reset", 1'b0, si);
    endtask
    // unused high bits read zero, unmapped places read zero
    function logic [7:0] ex(logic [7:0] a, logic [7:0] v);
        if (a == RDM_ADDR_DIV_HIGH) return v & 8'h3F;
        return (a == RDM_ADDR_IRQ_UPPER || a == RDM_ADDR_DIV_LOW) ? v : 8'h00;
    endfunction
    task give_verdict;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        k = $urandom(32'h13E8);
        repeat (12) @(negedge clk);
        rst = 0;
        check_reset;
        repeat (8) for (k = 8'h45; k < 8'h49; k++) begin
            d = 8'($urandom);
            if (k == 8'h47) d[4] = 1'b0;
            wr_then_rd(k[7:0], d); chk_rd("readback", ex(k[7:0], d), rd);
        end
        repeat (16) begin
            d = 8'($urandom); wr(8'h45, d);
            @(negedge clk); cv = 1'($urandom); sl = 1'($urandom);
            @(negedge clk); chk_bit("viol irq", cv & d[1], ci);
            chk_bit("loss irq", sl & d[0], si);
        end
        // mask open and events held: only the mid-run reset can silence the outputs
        wr(RDM_ADDR_IRQ_UPPER, 8'hFF); cv = 1; sl = 1;
        @(negedge clk); chk_bit("viol irq open", 1'b1, ci); rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        check_reset;
        for (k = 0; k < 4; k++) begin
            // high byte first so no step passes the limit
            wr(RDM_ADDR_DIV_HIGH, 8'hC0); wr(RDM_ADDR_DIV_LOW, k[7:0]); nd = 0;
            @(negedge clk); chk("factor", k[13:0], df);
            chk_bit("unsafe", exp_unsafe(k[13:0]), uns); tick = 1;
            repeat ((k + 1) * 4) @(negedge clk);
            tick = 0; repeat (3) @(negedge clk);
            chk("div ticks", 14'h4, nd[13:0]);
        end
        wr(RDM_ADDR_DIV_HIGH, 8'h30); wr(RDM_ADDR_DIV_LOW, 8'hD3);
        @(negedge clk); chk("factor max", 14'h30D3, df);
        chk_bit("unsafe max", exp_unsafe(14'h30D3), uns);
        give_verdict;
    end
endmodule
